/* hdl/slave_fifo_pkg.sv */
// Shared constants and types for the slave FIFO port
// Overview of operation
// - Sync read advances pointer, presents next word
// - Bus drive enable only gates data drive
// - Sync read data two cycles after strobe
// - Sync write flags update three cycles later
// - Sync address change shows three cycles later
// - Burst read: pointer steps each strobed edge
// - Drive enable shows previously addressed word
// - Flags configurable: empty, full, partial, dedicated/current
// - Socket change raises thread-ready once the switch delay ends
// - Switch delay only for 5-bit variant
// - Sync write captures word each strobed edge
// - Commit with last word commits short packet
// - Sync commit without write gives zero-length packet
// - Async read pointer steps on strobe release
// - Async write stores word on strobe release
// - Async write flags follow release by fixed delay
package slave_fifo_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 2;
    localparam int NUM_FIFO = 4;
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam int PIPE_DATA = 2;
    localparam int PIPE_FLAG = 3;
    localparam int PIPE_ADDR = 3;
    localparam int SWITCH_DELAY = 4;
    localparam int SW_W = 3;
    localparam int PARTIAL_LEVEL = 8;
    localparam int ASYNC_FLAG_DELAY = 2;
    localparam logic [CNT_W-1:0] FULL_LEVEL = 5'h10;
    localparam logic [CNT_W-1:0] PART_LEVEL = 5'h08;

    typedef enum logic [1:0] {
        FLAG_EMPTY,
        FLAG_FULL,
        FLAG_PARTIAL,
        FLAG_NONE
    } flag_kind_e;

    typedef struct packed {
        flag_kind_e kind;
        logic use_current;
        logic [ADDR_W-1:0] dedicated;
    } flag_cfg_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic last;
        logic zlp;
    } commit_word_s;
endpackage

/* hdl/word_fifo.sv */
// Parameterised valid/ready FIFO for committed packet words
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    assign o_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign o_valid = (cnt_reg != '0);
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem[rd_reg];

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_reg] <= i_data;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule

/* hdl/slave_fifo_port.sv */
// Slave FIFO port: external master reads and writes internal buffers
`timescale 1ns/1ps
module slave_fifo_port (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_sync_mode,
    input wire logic i_wide_addr,
    input wire logic i_link_clk,
    input wire logic i_port_select_n,
    input wire logic i_bus_drive_enable_n,
    input wire logic i_fifo_read_strobe_n,
    input wire logic i_fifo_write_strobe_n,
    input wire logic i_packet_commit_n,
    input wire logic i_socket_change_n,
    input wire logic [slave_fifo_pkg::ADDR_W-1:0] i_fifo_select,
    input wire logic [slave_fifo_pkg::DATA_W-1:0] i_data,
    output logic [slave_fifo_pkg::DATA_W-1:0] o_data,
    output logic o_data_oe,
    input wire slave_fifo_pkg::flag_cfg_s i_flag_a_cfg,
    input wire slave_fifo_pkg::flag_cfg_s i_flag_b_cfg,
    output logic o_flag_a,
    output logic o_flag_b,
    output logic o_thread_ready,
    input wire logic [slave_fifo_pkg::NUM_FIFO-1:0] i_fill_valid,
    input wire logic [slave_fifo_pkg::DATA_W-1:0] i_fill_data,
    output logic [slave_fifo_pkg::NUM_FIFO-1:0] o_fill_ready,
    output logic o_commit_valid,
    input wire logic i_commit_ready,
    output slave_fifo_pkg::commit_word_s o_commit_word,
    output logic [slave_fifo_pkg::ADDR_W-1:0] o_commit_fifo
);
    import slave_fifo_pkg::*;

    localparam int SYNC_W = 7 + ADDR_W + DATA_W;
    localparam int CW = $bits(commit_word_s);

    // Two-stage synchronisers for every pin
    // Bus words are sampled bit by bit; master holds them across the edge
    logic [SYNC_W-1:0] s1_reg;
    logic [SYNC_W-1:0] s2_reg;
    logic [SYNC_W-1:0] s3_reg;
    logic [SYNC_W-1:0] pins;

    assign pins = {i_link_clk, i_port_select_n, i_bus_drive_enable_n, i_fifo_read_strobe_n,
        i_fifo_write_strobe_n, i_packet_commit_n, i_socket_change_n, i_fifo_select, i_data};

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_reg <= {SYNC_W{1'b1}};
            s2_reg <= {SYNC_W{1'b1}};
            s3_reg <= {SYNC_W{1'b1}};
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    logic clk_s;
    logic sel;
    logic oe;
    logic rd;
    logic wr;
    logic pe;
    logic sw;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
    logic link_rise;
    logic rd_release;
    logic wr_release;
    logic sw_fall;

    assign clk_s = s2_reg[SYNC_W-1];
    assign sel = !s2_reg[SYNC_W-2];
    assign oe = !s2_reg[SYNC_W-3];
    assign rd = !s2_reg[SYNC_W-4];
    assign wr = !s2_reg[SYNC_W-5];
    assign pe = !s2_reg[SYNC_W-6];
    assign sw = !s2_reg[SYNC_W-7];
    assign addr = s2_reg[DATA_W +: ADDR_W];
    assign din = s2_reg[DATA_W-1:0];
    assign link_rise = clk_s && !s3_reg[SYNC_W-1];
    assign rd_release = !rd && !s3_reg[SYNC_W-4];
    assign wr_release = !wr && !s3_reg[SYNC_W-5];
    assign sw_fall = sw && s3_reg[SYNC_W-7];

    // Internal DMA buffers, one per thread
    logic [DATA_W-1:0] mem [NUM_FIFO][DEPTH];
    logic [PTR_W-1:0] wp_reg [NUM_FIFO];
    logic [PTR_W-1:0] rp_reg [NUM_FIFO];
    logic [CNT_W-1:0] cnt_reg [NUM_FIFO];
    logic [PTR_W-1:0] mark_reg [NUM_FIFO];

    logic rd_take;
    logic wr_take;
    logic pe_take;
    logic commit_in_ready;

    // Sync takes on link rising edges; async takes on strobe release
    always_comb begin
        rd_take = 1'b0;
        wr_take = 1'b0;
        pe_take = 1'b0;
        if (sel) begin
            if (i_sync_mode) begin
                rd_take = link_rise && rd;
                wr_take = link_rise && wr && cnt_reg[addr] != FULL_LEVEL;
                pe_take = link_rise && pe;
            end else begin
                rd_take = rd_release;
                wr_take = wr_release && cnt_reg[addr] != FULL_LEVEL;
                pe_take = wr_release && pe;
            end
        end
    end

    // Committing needs room downstream; a commit taken while the queue is full is dropped
    logic pe_go;
    logic pe_zlp;
    assign pe_go = pe_take && commit_in_ready;
    assign pe_zlp = i_sync_mode && !wr;

    function automatic logic is_sel(input logic [ADDR_W-1:0] a, input int f);
        return a == ADDR_W'(f);
    endfunction

    generate
        for (genvar f = 0; f < NUM_FIFO; f++) begin : g_fifo
            logic pop_host;
            logic push_fill;
            logic push_host;
            assign push_host = wr_take && is_sel(addr, f);
            assign pop_host = rd_take && is_sel(addr, f) && cnt_reg[f] != '0;
            assign push_fill = i_fill_valid[f] && !push_host && cnt_reg[f] != FULL_LEVEL;
            assign o_fill_ready[f] = !push_host && cnt_reg[f] != FULL_LEVEL;

            always_ff @(posedge i_ref_clk) begin
                if (push_host) begin
                    mem[f][wp_reg[f]] <= din;
                end else if (push_fill) begin
                    mem[f][wp_reg[f]] <= i_fill_data;
                end
            end

            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    wp_reg[f] <= '0;
                end else if (push_host || push_fill) begin
                    wp_reg[f] <= wp_reg[f] + 1'b1;
                end
            end

            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    rp_reg[f] <= '0;
                end else if (pop_host) begin
                    rp_reg[f] <= rp_reg[f] + 1'b1;
                end
            end

            // Push and pop in one cycle leave the level unchanged
            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    cnt_reg[f] <= '0;
                end else if ((push_host || push_fill) && !pop_host) begin
                    cnt_reg[f] <= cnt_reg[f] + 1'b1;
                end else if (pop_host && !(push_host || push_fill)) begin
                    cnt_reg[f] <= cnt_reg[f] - 1'b1;
                end
            end

            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    mark_reg[f] <= '0;
                end else if (pe_go && is_sel(addr, f)) begin
                    mark_reg[f] <= wp_reg[f] + PTR_W'(wr_take);
                end
            end
        end
    endgenerate

    // Commit queue carries packet boundaries to the buffer engine
    commit_word_s cq_in;
    logic [CW-1:0] cq_out;
    assign cq_in.data = din;
    assign cq_in.last = 1'b1;
    assign cq_in.zlp = pe_zlp;

    word_fifo #(
        .WIDTH(CW),
        .DEPTH(DEPTH)
    ) u_commit_q (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_valid(pe_take),
        .o_ready(commit_in_ready),
        .i_data(cq_in),
        .o_valid(o_commit_valid),
        .i_ready(i_commit_ready),
        .o_data(cq_out)
    );
    assign o_commit_word = commit_word_s'(cq_out);

    // Latest commit's thread; matches the queue head only with one entry waiting
    logic [ADDR_W-1:0] cfifo_reg;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cfifo_reg <= '0;
        end else if (pe_go) begin
            cfifo_reg <= addr;
        end
    end
    assign o_commit_fifo = cfifo_reg;

    // Address pipeline: sync changes reach bus and flags three link edges later; async loads all stages at once
    logic [ADDR_W-1:0] apipe_reg [PIPE_ADDR];
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < PIPE_ADDR; i++) begin
                apipe_reg[i] <= '0;
            end
        end else if (!i_sync_mode) begin
            for (int i = 0; i < PIPE_ADDR; i++) begin
                apipe_reg[i] <= addr;
            end
        end else if (link_rise) begin
            apipe_reg[0] <= addr;
            for (int i = 1; i < PIPE_ADDR; i++) begin
                apipe_reg[i] <= apipe_reg[i-1];
            end
        end
    end
    logic [ADDR_W-1:0] view_addr;
    assign view_addr = apipe_reg[PIPE_ADDR-1];

    // Read data pipeline, two link edges of latency
    logic [DATA_W-1:0] dpipe_reg [PIPE_DATA];
    logic [DATA_W-1:0] head;
    assign head = mem[view_addr][rp_reg[view_addr]];
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < PIPE_DATA; i++) begin
                dpipe_reg[i] <= '0;
            end
        end else if (!i_sync_mode || link_rise) begin
            dpipe_reg[0] <= head;
            dpipe_reg[1] <= dpipe_reg[0];
        end
    end

    // Drive enable touches only the output enable, never pointers
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_data <= '0;
        end else begin
            o_data <= i_sync_mode ? dpipe_reg[PIPE_DATA-1] : dpipe_reg[0];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_data_oe <= 1'b0;
        end else begin
            o_data_oe <= sel && oe;
        end
    end

    // Flag level select shared by both flag outputs
    function automatic logic flag_of(input flag_cfg_s c, input logic [CNT_W-1:0] n);
        case (c.kind)
            FLAG_EMPTY: return n == '0;
            FLAG_FULL: return n == FULL_LEVEL;
            FLAG_PARTIAL: return n >= PART_LEVEL;
            default: return 1'b0;
        endcase
    endfunction

    // Sync flags lag three link edges; async flags lag a fixed delay
    logic [1:0] fpipe_reg [PIPE_FLAG];
    logic [1:0] fraw;
    assign fraw[0] = flag_of(i_flag_a_cfg,
        cnt_reg[i_flag_a_cfg.use_current ? view_addr : i_flag_a_cfg.dedicated]);
    assign fraw[1] = flag_of(i_flag_b_cfg,
        cnt_reg[i_flag_b_cfg.use_current ? view_addr : i_flag_b_cfg.dedicated]);
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < PIPE_FLAG; i++) begin
                fpipe_reg[i] <= '0;
            end
        end else if (!i_sync_mode || link_rise) begin
            fpipe_reg[0] <= fraw;
            for (int i = 1; i < PIPE_FLAG; i++) begin
                fpipe_reg[i] <= fpipe_reg[i-1];
            end
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_flag_a <= 1'b0;
        end else begin
            o_flag_a <= i_sync_mode ? fpipe_reg[PIPE_FLAG-1][0] : fpipe_reg[ASYNC_FLAG_DELAY-1][0];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_flag_b <= 1'b0;
        end else begin
            o_flag_b <= i_sync_mode ? fpipe_reg[PIPE_FLAG-1][1] : fpipe_reg[ASYNC_FLAG_DELAY-1][1];
        end
    end

    // Socket switch: ready once the delay count reaches zero; can_move is always true
    logic [SW_W-1:0] sw_cnt_reg;
    logic [ADDR_W-1:0] sock_reg;
    logic can_move;
    assign can_move = cnt_reg[sock_reg] != FULL_LEVEL || cnt_reg[sock_reg] != '0;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sock_reg <= '0;
        end else if (sel && sw_fall) begin
            sock_reg <= addr;
        end
    end

    // Narrow variant loads zero, so its thread switches at once
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sw_cnt_reg <= '0;
        end else if (sel && sw_fall) begin
            sw_cnt_reg <= i_wide_addr ? SW_W'(SWITCH_DELAY) : '0;
        end else if (sw_cnt_reg != '0 && (i_sync_mode ? link_rise : 1'b1)) begin
            sw_cnt_reg <= sw_cnt_reg - 1'b1;
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_thread_ready <= 1'b0;
        end else begin
            o_thread_ready <= sw_cnt_reg == '0 && can_move;
        end
    end
endmodule

/* bench/slave_fifo_port_chk.sv */
// Port-level assertions for the slave FIFO port
`timescale 1ns/1ps
module slave_fifo_port_chk (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_port_select_n,
    input wire logic i_bus_drive_enable_n,
    input wire logic i_fifo_read_strobe_n,
    input wire logic i_fifo_write_strobe_n,
    input wire logic [slave_fifo_pkg::ADDR_W-1:0] i_fifo_select,
    input wire logic [slave_fifo_pkg::NUM_FIFO-1:0] i_fill_valid,
    input wire slave_fifo_pkg::flag_cfg_s i_flag_a_cfg,
    input wire slave_fifo_pkg::flag_cfg_s i_flag_b_cfg,
    input wire logic [slave_fifo_pkg::DATA_W-1:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_flag_a,
    input wire logic o_flag_b,
    input wire logic o_commit_valid,
    input wire logic i_commit_ready,
    input wire slave_fifo_pkg::commit_word_s o_commit_word,
    input wire logic [slave_fifo_pkg::ADDR_W-1:0] o_commit_fifo
);
    import slave_fifo_pkg::*;
    logic [7:0] quiet_cnt;
    logic [5:0] drive_cnt;
    logic [5:0] desel_cnt;
    logic [ADDR_W+1:0] pins_q;
    // Long quiet window: address changes need three slow link edges
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            quiet_cnt <= 8'h00;
            pins_q <= '1;
        end else begin
            pins_q <= {i_port_select_n, i_bus_drive_enable_n, i_fifo_select};
            if (!i_fifo_read_strobe_n || !i_fifo_write_strobe_n || (|i_fill_valid)
                || pins_q != {i_port_select_n, i_bus_drive_enable_n, i_fifo_select})
                quiet_cnt <= 8'h00;
            else if (quiet_cnt != 8'hff)
                quiet_cnt <= quiet_cnt + 8'h01;
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            drive_cnt <= 6'h00;
            desel_cnt <= 6'h00;
        end else begin
            drive_cnt <= (i_port_select_n || i_bus_drive_enable_n) ? 6'h00
                : drive_cnt + {5'h00, drive_cnt != 6'h3f};
            desel_cnt <= !i_port_select_n ? 6'h00 : desel_cnt + {5'h00, desel_cnt != 6'h3f};
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    desel_oe_a: assert property (desel_cnt >= 6'h30 |-> !o_data_oe)
        else $error("data bus driven while deselected");
    oe_release_a: assert property ($rose(i_bus_drive_enable_n) |-> ##[1:40] !o_data_oe)
        else $error("bus drive not released");
    oe_drive_a: assert property (drive_cnt == 6'h28 |-> o_data_oe)
        else $error("bus not driven with drive enable");
    data_quiet_a: assert property (quiet_cnt == 8'hff |-> $stable(o_data))
        else $error("read data moved without a read");
    commit_quiet_a: assert property ((i_port_select_n && !i_commit_ready) [*8]
        |-> !$rose(o_commit_valid))
        else $error("commit while deselected");
    commit_hold_a: assert property (o_commit_valid && !i_commit_ready |=> o_commit_valid
        && $stable(o_commit_word) && $stable(o_commit_fifo))
        else $error("commit word dropped while stalled");
    flag_a_none_a: assert property ((i_flag_a_cfg.kind == FLAG_NONE) [*6] |-> !o_flag_a)
        else $error("flag a set with no status chosen");
    flag_b_none_a: assert property (i_flag_b_cfg.kind == FLAG_NONE ##1
        $stable(i_flag_b_cfg) [*5] |-> !o_flag_b)
        else $error("flag b set with no status chosen");
endmodule
bind slave_fifo_port slave_fifo_port_chk u_chk (.*);

/* bench/fifo_master_model.sv */
// Behavioural external master driving the slave FIFO pins
`timescale 1ns/1ps
module fifo_master_model (
    input wire logic i_ref_clk,
    input wire logic [slave_fifo_pkg::DATA_W-1:0] i_bus_data,
    output logic o_link_clk,
    output logic o_select_n,
    output logic o_drive_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_commit_n,
    output logic o_switch_n,
    output logic [slave_fifo_pkg::ADDR_W-1:0] o_fifo_sel,
    output logic [slave_fifo_pkg::DATA_W-1:0] o_data
);
    import slave_fifo_pkg::*;
    logic run = 1'b0;
    logic [DATA_W-1:0] rd_q[$];
    // Link clock stands still between frames
    initial begin
        {o_select_n, o_drive_n, o_rd_n, o_wr_n, o_commit_n} = 5'h1f;
        o_switch_n = 1'b1;
        o_fifo_sel = 2'h0;
        o_data = 16'h0000;
        o_link_clk = 1'b0;
        forever begin
            #32;
            o_link_clk = run & ~o_link_clk;
        end
    end
    // Pins move mid-period, well clear of the sampled rise
    task automatic edges(input int n);
        repeat (n) @(negedge o_link_clk);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic frame_end();
        {o_select_n, o_drive_n, o_rd_n, o_wr_n, o_commit_n} = 5'h1f;
        o_data = ~o_data;
        edges(4);
        run = 1'b0;
    endtask
    task automatic sync_write(input logic cs_n, input logic [1:0] sel, input int n,
                              input logic [15:0] base);
        run = 1'b1;
        edges(1);
        o_select_n = cs_n;
        o_fifo_sel = sel;
        for (int k = 0; k < n; k++) begin
            o_data = base + 16'(k);
            o_wr_n = 1'b0;
            o_commit_n = (k != n - 1);
            edges(1);
        end
        if (n == 0) begin
            o_commit_n = 1'b0;
            edges(1);
        end
        frame_end();
    endtask
    task automatic sync_read(input logic [1:0] sel, input int n);
        run = 1'b1;
        edges(1);
        o_select_n = 1'b0;
        o_fifo_sel = sel;
        o_drive_n = 1'b0;
        edges(4);
        rd_q = {};
        o_rd_n = 1'b0;
        for (int j = 0; j <= n; j++) begin
            edges(1);
            rd_q.push_back(i_bus_data);
            o_rd_n = (j + 1 >= n);
        end
        frame_end();
    endtask
    task automatic async_write(input logic [1:0] sel, input logic [15:0] w);
        o_select_n = 1'b0;
        o_fifo_sel = sel;
        step(2);
        o_wr_n = 1'b0;
        o_commit_n = 1'b0;
        o_data = w;
        step(10);
        o_wr_n = 1'b1;
        step(4);
        o_select_n = 1'b1;
        o_commit_n = 1'b1;
        o_data = ~w;
    endtask
    task automatic socket_switch(input logic [1:0] sel, input int n);
        run = 1'b1;
        edges(1);
        o_select_n = 1'b0;
        o_fifo_sel = sel;
        o_switch_n = 1'b0;
        edges(n);
        o_switch_n = 1'b1;
    endtask
    task automatic idle_edges(input int n);
        run = 1'b1;
        edges(n);
        run = 1'b0;
    endtask
endmodule

/* bench/slave_fifo_port_test.sv */
// Self-checking bench for the slave FIFO port
`timescale 1ns/1ps
module slave_fifo_port_test;
    import slave_fifo_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sync_mode = 1'b1;
    logic link_clk, sel_n, drv_n, rd_n, wr_n, cmt_n, oe, flag_a, flag_b, cv, sw_n, tready;
    logic wide_addr = 1'b0;
    logic cready = 1'b0;
    logic [1:0] fifo_sel, cfifo;
    logic [15:0] wdata, rdata;
    logic [15:0] fill_data = 16'h0000;
    logic [3:0] fill_valid = 4'h0;
    logic [3:0] fill_ready;
    flag_cfg_s cfg_a = '{FLAG_NONE, 1'b0, 2'h0};
    flag_cfg_s cfg_b = '{FLAG_NONE, 1'b0, 2'h0};
    commit_word_s cword;
    int errors = 0;
    int num_checks = 0;
    fifo_master_model master (.i_ref_clk(clk), .i_bus_data(rdata), .o_link_clk(link_clk),
        .o_select_n(sel_n), .o_drive_n(drv_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .o_commit_n(cmt_n), .o_switch_n(sw_n), .o_fifo_sel(fifo_sel), .o_data(wdata));
    slave_fifo_port DUT (.i_ref_clk(clk), .i_rst(rst), .i_sync_mode(sync_mode),
        .i_wide_addr(wide_addr), .i_link_clk(link_clk), .i_port_select_n(sel_n),
        .i_bus_drive_enable_n(drv_n), .i_fifo_read_strobe_n(rd_n),
        .i_fifo_write_strobe_n(wr_n), .i_packet_commit_n(cmt_n), .i_socket_change_n(sw_n),
        .i_fifo_select(fifo_sel), .i_data(wdata), .o_data(rdata), .o_data_oe(oe),
        .i_flag_a_cfg(cfg_a), .i_flag_b_cfg(cfg_b), .o_flag_a(flag_a), .o_flag_b(flag_b),
        .o_thread_ready(tready), .i_fill_valid(fill_valid), .i_fill_data(fill_data),
        .o_fill_ready(fill_ready), .o_commit_valid(cv), .i_commit_ready(cready),
        .o_commit_word(cword), .o_commit_fifo(cfifo));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Queue is stalled until the bench pops, one word at a time
    task automatic pop(input logic [1:0] f, input logic [17:0] w, input logic [17:0] m);
        int k;
        for (k = 0; k < 300 && cv !== 1'b1; k++)
            tick();
        if (k == 300) begin
            errors++;
            final_report();
        end
        check("commit word", cword & m, w);
        check("commit fifo", cfifo, f);
        cready = 1'b1;
        tick();
        cready = 1'b0;
    endtask
    task automatic sc_deselect();
        master.sync_write(1'b1, 2'h1, 2, 16'hdead);
        check("commit valid", cv, 1'b0);
        check("bus drive", oe, 1'b0);
    endtask
    task automatic sc_sync_write();
        master.sync_write(1'b0, 2'h1, 3, 16'h1230);
        pop(2'h1, {16'h1232, 1'b1, 1'b0}, 18'h3_ffff);
        master.sync_read(2'h1, 3);
        for (int j = 0; j <= 3; j++)
            check("write word", master.rd_q[j], 16'h1230 + 16'(j > 0 ? j - 1 : 0));
        master.sync_write(1'b0, 2'h3, 0, 16'h0000);
        pop(2'h3, 18'h0_0003, 18'h0_0003);
    endtask
    task automatic sc_async_write();
        sync_mode = 1'b0;
        tick();
        master.async_write(2'h0, 16'h5a5a);
        pop(2'h0, {16'h5a5a, 1'b1, 1'b0}, 18'h3_ffff);
        sync_mode = 1'b1;
    endtask
    task automatic sc_read();
        int cnt;
        cfg_a = '{FLAG_EMPTY, 1'b0, 2'h2};
        cfg_b = '{FLAG_FULL, 1'b0, 2'h2};
        fill_valid = 4'h4;
        for (cnt = 0; cnt < 40 && fill_ready[2]; cnt++) begin
            fill_data = 16'ha000 + 16'(cnt);
            tick();
        end
        fill_valid = 4'h0;
        check("fill count", cnt, DEPTH);
        master.idle_edges(4);
        repeat (8) tick();
        check("empty flag", flag_a, 1'b0);
        check("full flag", flag_b, 1'b1);
        master.sync_read(2'h2, 16);
        for (int j = 0; j <= 16; j++)
            check("read word", master.rd_q[j], 16'ha000 + 16'(j > 0 ? j - 1 : 0));
        repeat (8) tick();
        check("empty flag", flag_a, 1'b1);
        check("full flag", flag_b, 1'b0);
        check("fill ready", fill_ready[2], 1'b1);
    endtask
    task automatic sc_switch();
        wide_addr = 1'b1;
        master.socket_switch(2'h1, 2);
        check("thread ready", tready, 1'b0);
        master.frame_end();
        check("thread ready", tready, 1'b1);
        wide_addr = 1'b0;
        master.socket_switch(2'h2, 1);
        check("thread ready", tready, 1'b1);
        master.frame_end();
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (4) tick();
        sc_deselect();
        sc_sync_write();
        sc_async_write();
        sc_read();
        sc_switch();
        final_report();
    end
endmodule
